// *** shcp_cfg.svh ***
`ifndef SHCP_CFG_SVH
`define SHCP_CFG_SVH
// Function
// - Attention byte: action code high, device low
// - Codes 0,1,3: reset, immediate, control block
// - Code D sets source-ident bit by device
// - Code E end-of-interrupt; others reserved/dependent
// - Control bit 7 starts command reset, busy
// - Command reset aborts host access to all but control port
// - Clear-on-read always; status read clears interrupts
// - Reject-reset clears busy and reject, self-clears
// - Control bits 4,3-2 host RW, local RO
// - Control bit 1 enables DMA
// - Control bit 0 enables host interrupts
// - Control reads 40 after reset, C0 after command
// - Cause port: cause high, device low
// - Cause port holds through command reset
// - Reject with busy: status 001 watchdog
// - Reject blocks attention/command except code D
// - DMA channel bits set on enabled termination
// - Interrupt-valid raises host interrupt
// - Status read clears valid and DMA bits
// - Attention write sets busy except D; busy blocks
// - Accepted attention latches, interrupts local; read clears
// - Command write ignored while reject or busy
// - Byte DA sets source bit 10 only
`define SHCP_OFS_COMMAND     8'h00
`define SHCP_OFS_ATTENTION   8'h04
`define SHCP_OFS_CONTROL     8'h05
`define SHCP_OFS_CAUSE       8'h06
`define SHCP_OFS_BUSY_STATE  8'h07
`define SHCP_OFS_SOURCE      8'h14
`define SHCP_CTL_RST_VAL     8'h40
`define SHCP_CTL_CMDRST_VAL  8'hC0
`define SHCP_CTL_CMDRST_BIT  7
`define SHCP_CTL_REJRST_BIT  5
`define SHCP_CTL_DMA_BIT     1
`define SHCP_CTL_IRQ_BIT     0
`define SHCP_CTL_HOST_MASK   8'h1F
`define SHCP_CODE_RESET      4'h0
`define SHCP_CODE_IMMED      4'h1
`define SHCP_CODE_BLOCK      4'h3
`define SHCP_CODE_MOVE       4'hD
`define SHCP_CODE_EOI        4'hE
`define SHCP_EXC_WATCHDOG    3'h1
`define SHCP_CMDRST_TIME_NS  50000
`define SHCP_CLK_NS          20
`endif

// *** shcp_pkg.sv ***
package shcp_pkg;
    typedef enum logic [2:0] {
        SHCP_ACT_NONE   = 3'h0,
        SHCP_ACT_RESET  = 3'h1,
        SHCP_ACT_IMMED  = 3'h2,
        SHCP_ACT_BLOCK  = 3'h3,
        SHCP_ACT_MOVE   = 3'h4,
        SHCP_ACT_EOI    = 3'h5,
        SHCP_ACT_DEVDEP = 3'h6,
        SHCP_ACT_RSVD   = 3'h7
    } shcp_action_type;
    typedef struct packed {
        logic       req;
        logic       write;
        logic [7:0] addr;
        logic [31:0] wdata;
    } shcp_access_type;
    typedef struct packed {
        logic [3:0] code;
        logic [3:0] device;
    } shcp_attention_port_type;
endpackage

// *** shcp_attention_port_decode.sv ***
`timescale 1ns/1ps
`include "shcp_cfg.svh"
module shcp_attention_port_decode (
    input  wire logic [7:0]            attention_port_byte_i,
    output shcp_pkg::shcp_action_type  action_o,
    output logic [15:0]                source_bit_o
);
    shcp_pkg::shcp_attention_port_type a;
    always_comb begin
        a = attention_port_byte_i;
        source_bit_o = 16'h0001 << a.device;
        case (a.code)
            `SHCP_CODE_RESET: action_o = shcp_pkg::SHCP_ACT_RESET;
            `SHCP_CODE_IMMED: action_o = shcp_pkg::SHCP_ACT_IMMED;
            `SHCP_CODE_BLOCK: action_o = shcp_pkg::SHCP_ACT_BLOCK;
            `SHCP_CODE_MOVE:  action_o = shcp_pkg::SHCP_ACT_MOVE;
            `SHCP_CODE_EOI:   action_o = shcp_pkg::SHCP_ACT_EOI;
            4'h4, 4'hF:       action_o = shcp_pkg::SHCP_ACT_DEVDEP;
            default:          action_o = shcp_pkg::SHCP_ACT_RSVD;
        endcase
    end
endmodule

// *** shcp_sync.sv ***
`timescale 1ns/1ps
module shcp_sync (
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic [2:0] async_i,
    output logic [2:0]      sync_o
);
    logic [2:0] stage1;
    logic [2:0] next_stage1;
    logic [2:0] next_sync;
    always_comb begin
        next_stage1 = async_i;
        next_sync = stage1;
    end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stage1 <= 3'h0;
            sync_o <= 3'h0;
        end else begin
            stage1 <= next_stage1;
            sync_o <= next_sync;
        end
    end
endmodule

// *** shcp_ports.sv ***
`timescale 1ns/1ps
`include "shcp_cfg.svh"
module shcp_ports (
    input  wire logic                   clk_i,
    input  wire logic                   arst_n_i,
    // Host side, one-cycle access strobe
    input  wire shcp_pkg::shcp_access_type host_acc_i,
    output logic [31:0]                 host_rdata_o,
    output logic                        host_ack_o,
    output logic                        host_abort_o,
    // Local side
    input  wire shcp_pkg::shcp_access_type local_acc_i,
    output logic [31:0]                 local_rdata_o,
    output logic                        local_ack_o,
    input  wire logic [1:0]             dma_term_i,
    input  wire logic [1:0]             dma_dir_en_i,
    input  wire logic                   watchdog_i,
    output logic                        attention_port_irq_o,
    output logic                        cmd_reset_o,
    output logic                        dma_enable_o,
    output logic                        host_irq_o,
    output shcp_pkg::shcp_action_type   attention_port_action_o,
    output logic [15:0]                 source_ident_bits_o
);
    // ****************************************
    // Decode and synchronisers
    // ****************************************
    shcp_pkg::shcp_action_type action;
    logic [15:0]               src_bit;
    logic [2:0]                ev_sync;
    logic [2:0]                ev_prev;
    logic [2:0]                next_ev_prev;
    logic [1:0]                dma_rise;
    logic                      wd_rise;

    shcp_attention_port_decode u_dec (
        .attention_port_byte_i  (host_acc_i.wdata[7:0]),
        .action_o     (action),
        .source_bit_o (src_bit)
    );

    // Termination and watchdog come from outside this clock
    shcp_sync u_sync (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .async_i  ({watchdog_i, dma_term_i}),
        .sync_o   (ev_sync)
    );

    // ****************************************
    // Register state
    // ****************************************
    logic [7:0]  control;
    logic [7:0]  cause;
    logic [7:0]  attention_port;
    logic [31:0] command;
    logic [2:0]  status;
    logic        reject;
    logic        ivalid;
    logic [1:0]  dma_int;
    logic        busy;
    logic        attention_port_pend;
    logic [15:0] source;
    logic [7:0]  next_control;
    logic [7:0]  next_cause;
    logic [7:0]  next_attention_port;
    logic [31:0] next_command;
    logic [2:0]  next_status;
    logic        next_reject;
    logic        next_ivalid;
    logic [1:0]  next_dma_int;
    logic        next_busy;
    logic        next_attention_port_pend;
    logic [15:0] next_source;
    logic [31:0] next_host_rdata;
    logic [31:0] next_local_rdata;
    logic        next_host_ack;
    logic        next_host_abort;
    logic        next_local_ack;
    shcp_pkg::shcp_action_type next_action;

    logic h_wr;
    logic h_rd;
    logic l_wr;
    logic l_rd;
    logic in_cmdrst;
    logic aborted;
    logic blocked;

    function automatic logic hit(input shcp_pkg::shcp_access_type acc, input logic [7:0] ofs);
        hit = acc.req && (acc.addr == ofs);
    endfunction

    always_comb begin
        in_cmdrst = control[`SHCP_CTL_CMDRST_BIT];
        // Every host access but the control port aborts during command reset; local accesses go on
        aborted = in_cmdrst && host_acc_i.req && (host_acc_i.addr != `SHCP_OFS_CONTROL);
        h_wr = host_acc_i.req && host_acc_i.write && !aborted;
        h_rd = host_acc_i.req && !host_acc_i.write && !aborted;
        l_wr = local_acc_i.req && local_acc_i.write;
        l_rd = local_acc_i.req && !local_acc_i.write;
        blocked = reject || busy;
        next_ev_prev = ev_sync;
        dma_rise = ev_sync[1:0] & ~ev_prev[1:0];
        wd_rise = ev_sync[2] & ~ev_prev[2];
    end

    always_comb begin
        next_control = control;
        next_cause = cause;
        next_attention_port = attention_port;
        next_command = command;
        next_status = status;
        next_reject = reject;
        next_ivalid = ivalid;
        next_dma_int = dma_int;
        next_busy = busy;
        next_attention_port_pend = attention_port_pend;
        next_source = source;
        next_action = attention_port_action_o;
        next_host_rdata = 32'h0000_0000;
        next_local_rdata = 32'h0000_0000;
        next_host_ack = host_acc_i.req && !aborted;
        next_host_abort = aborted;
        next_local_ack = local_acc_i.req;

        // Clears first, so a same-cycle set wins
        if (l_rd && hit(local_acc_i, `SHCP_OFS_ATTENTION)) begin
            next_attention_port_pend = 1'b0;
        end
        if (h_rd && hit(host_acc_i, `SHCP_OFS_BUSY_STATE)) begin
            next_ivalid = 1'b0;
            next_dma_int = 2'b00;
        end

        // Host writes
        if (h_wr && host_acc_i.addr == `SHCP_OFS_CONTROL) begin
            next_control = {host_acc_i.wdata[7], 1'b1, 1'b0, host_acc_i.wdata[4:0]};
            if (host_acc_i.wdata[`SHCP_CTL_CMDRST_BIT]) begin
                next_busy = 1'b1;
            end
        end
        if (h_wr && hit(host_acc_i, `SHCP_OFS_COMMAND) && !blocked) begin
            next_command = host_acc_i.wdata;
        end
        if (h_wr && hit(host_acc_i, `SHCP_OFS_ATTENTION)) begin
            if (action == shcp_pkg::SHCP_ACT_MOVE) begin
                next_source = source | src_bit;
            end else if (!blocked) begin
                next_attention_port = host_acc_i.wdata[7:0];
                next_attention_port_pend = 1'b1;
                next_busy = 1'b1;
                next_action = action;
            end
        end

        // Local writes post status back
        if (l_wr && hit(local_acc_i, `SHCP_OFS_CAUSE)) begin
            next_cause = local_acc_i.wdata[7:0];
        end
        if (l_wr && hit(local_acc_i, `SHCP_OFS_BUSY_STATE)) begin
            next_status = local_acc_i.wdata[7:5];
            next_reject = local_acc_i.wdata[4];
            // A host set in this same cycle survives the local write
            next_busy = local_acc_i.wdata[0] || (next_busy && !busy);
            next_ivalid = next_ivalid | local_acc_i.wdata[1];
        end
        if (l_wr && hit(local_acc_i, `SHCP_OFS_SOURCE)) begin
            next_source = next_source & local_acc_i.wdata[15:0];
        end

        if (in_cmdrst) begin
            next_busy = 1'b1;
        end
        // Reject-reset takes priority over a same-cycle local status write
        if (h_wr && hit(host_acc_i, `SHCP_OFS_CONTROL) && host_acc_i.wdata[`SHCP_CTL_REJRST_BIT]) begin
            next_busy = next_control[`SHCP_CTL_CMDRST_BIT];
            next_reject = 1'b0;
        end
        // Events win over the read clear and the reject reset
        next_dma_int = next_dma_int | (dma_rise & dma_dir_en_i);
        if (wd_rise) begin
            next_status = `SHCP_EXC_WATCHDOG;
            next_reject = 1'b1;
            next_busy = 1'b1;
            next_ivalid = 1'b1;
        end

        // Read data
        if (h_rd) begin
            case (host_acc_i.addr)
                `SHCP_OFS_COMMAND:    next_host_rdata = command;
                `SHCP_OFS_ATTENTION:  next_host_rdata = {24'h00_0000, attention_port};
                `SHCP_OFS_CONTROL:    next_host_rdata = {24'h00_0000, control};
                `SHCP_OFS_CAUSE:      next_host_rdata = {24'h00_0000, cause};
                `SHCP_OFS_BUSY_STATE: next_host_rdata = {24'h00_0000, status, reject, dma_int, ivalid, busy};
                default:              next_host_rdata = 32'h0000_0000;
            endcase
        end
        if (l_rd) begin
            case (local_acc_i.addr)
                `SHCP_OFS_COMMAND:    next_local_rdata = command;
                `SHCP_OFS_ATTENTION:  next_local_rdata = {24'h00_0000, attention_port};
                `SHCP_OFS_CONTROL:    next_local_rdata = {24'h00_0000, control};
                `SHCP_OFS_CAUSE:      next_local_rdata = {24'h00_0000, cause};
                `SHCP_OFS_BUSY_STATE: next_local_rdata = {24'h00_0000, status, reject, dma_int, ivalid, busy};
                `SHCP_OFS_SOURCE:     next_local_rdata = {16'h0000, source};
                default:              next_local_rdata = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            control <= `SHCP_CTL_RST_VAL;
            cause <= 8'h00;
            attention_port <= 8'h00;
            command <= 32'h0000_0000;
            status <= 3'h0;
            reject <= 1'b0;
            ivalid <= 1'b0;
            dma_int <= 2'b00;
            busy <= 1'b0;
            attention_port_pend <= 1'b0;
            source <= 16'h0000;
            ev_prev <= 3'h0;
            attention_port_action_o <= shcp_pkg::SHCP_ACT_NONE;
            host_rdata_o <= 32'h0000_0000;
            local_rdata_o <= 32'h0000_0000;
            host_ack_o <= 1'b0;
            host_abort_o <= 1'b0;
            local_ack_o <= 1'b0;
        end else begin
            control <= next_control;
            cause <= next_cause;
            attention_port <= next_attention_port;
            command <= next_command;
            status <= next_status;
            reject <= next_reject;
            ivalid <= next_ivalid;
            dma_int <= next_dma_int;
            busy <= next_busy;
            attention_port_pend <= next_attention_port_pend;
            source <= next_source;
            ev_prev <= next_ev_prev;
            attention_port_action_o <= next_action;
            host_rdata_o <= next_host_rdata;
            local_rdata_o <= next_local_rdata;
            host_ack_o <= next_host_ack;
            host_abort_o <= next_host_abort;
            local_ack_o <= next_local_ack;
        end
    end

    always_comb begin
        attention_port_irq_o = attention_port_pend;
        cmd_reset_o = control[`SHCP_CTL_CMDRST_BIT];
        dma_enable_o = control[`SHCP_CTL_DMA_BIT];
        host_irq_o = control[`SHCP_CTL_IRQ_BIT] && (ivalid || (|dma_int));
        source_ident_bits_o = source;
    end
endmodule

// *** shcp_ports_monitor.sv ***
`timescale 1ns/1ps
// ****
// Host and local port checks
// ****
module shcp_ports_monitor (
    input wire logic                      clk_i,
    input wire logic                      arst_n_i,
    input wire shcp_pkg::shcp_access_type host_acc_i,
    input wire logic [31:0]               host_rdata_o,
    input wire logic                      host_ack_o,
    input wire logic                      host_abort_o,
    input wire shcp_pkg::shcp_access_type local_acc_i,
    input wire logic [31:0]               local_rdata_o,
    input wire logic                      attention_port_irq_o,
    input wire logic                      cmd_reset_o,
    input wire logic                      dma_enable_o,
    input wire logic                      host_irq_o,
    input wire logic [15:0]               source_ident_bits_o
);
    wire logic       h_wr = host_acc_i.req && host_acc_i.write;
    wire logic       h_rd = host_acc_i.req && !host_acc_i.write;
    wire logic [7:0] h_a  = host_acc_i.addr;
    wire logic       l_rd = local_acc_i.req && !local_acc_i.write;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_rr_write;
        h_wr && h_a == 8'h05 && host_acc_i.wdata[5] && !host_acc_i.wdata[7] && !cmd_reset_o;
    endsequence
    sequence s_state_read;
        h_rd && h_a == 8'h07 && !cmd_reset_o;
    endsequence
    a_abort_guard: assert property (host_acc_i.req && cmd_reset_o && h_a != 8'h05 |=> host_abort_o && !host_ack_o)
        else $error("access not aborted in command reset");
    a_ctl_open: assert property (host_acc_i.req && h_a == 8'h05 |=> host_ack_o && !host_abort_o)
        else $error("control access not acked");
    a_ctl_read: assert property (h_rd && h_a == 8'h05 |=> host_rdata_o[31:8] == 24'h0 && host_rdata_o[6])
        else $error("control readback malformed");
    a_dma_follow: assert property (h_wr && h_a == 8'h05 && !host_acc_i.wdata[7]
        |=> dma_enable_o == $past(host_acc_i.wdata[1]) && !cmd_reset_o)
        else $error("dma enable does not follow control write");
    a_cmd_reset: assert property (h_wr && h_a == 8'h05 && host_acc_i.wdata[7] |=> cmd_reset_o)
        else $error("command reset not raised");
    a_reset_busy: assert property (l_rd && local_acc_i.addr == 8'h07 && cmd_reset_o |=> local_rdata_o[0])
        else $error("busy clear during command reset");
    a_reject_clear: assert property (s_rr_write ##2 s_state_read |=> !host_rdata_o[4] && !host_rdata_o[0])
        else $error("reject reset left busy or reject");
    a_read_clears: assert property (s_state_read |=> !host_irq_o)
        else $error("host irq stays after state read");
    a_attention_port_clear: assert property (l_rd && local_acc_i.addr == 8'h04 |=> !attention_port_irq_o)
        else $error("attention irq stays after local read");
    a_move_bit: assert property (h_wr && h_a == 8'h04 && host_acc_i.wdata[7:4] == 4'hD && !cmd_reset_o
        |=> source_ident_bits_o[$past(host_acc_i.wdata[3:0])])
        else $error("move code did not set source bit");
endmodule
bind shcp_ports shcp_ports_monitor u_mon (.clk_i(clk_i), .arst_n_i(arst_n_i), .host_acc_i(host_acc_i),
    .host_rdata_o(host_rdata_o), .host_ack_o(host_ack_o), .host_abort_o(host_abort_o),
    .local_acc_i(local_acc_i), .local_rdata_o(local_rdata_o), .attention_port_irq_o(attention_port_irq_o),
    .cmd_reset_o(cmd_reset_o), .dma_enable_o(dma_enable_o), .host_irq_o(host_irq_o),
    .source_ident_bits_o(source_ident_bits_o));

// *** shcp_host_model.sv ***
`timescale 1ns/1ps
// ****
// Host bus master
// ****
module shcp_host_model (
    input  wire logic                clk_i,
    input  wire logic                host_ack_i,
    input  wire logic                host_abort_i,
    input  wire logic [31:0]         host_rdata_i,
    output shcp_pkg::shcp_access_type host_acc_o
);
    initial host_acc_o = '0;
    // Entered just after a rising edge; ab is {abort, ack}
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] rd, output logic [1:0] ab);
        host_acc_o = '{req: 1'b1, write: wr, addr: a, wdata: d};
        @(posedge clk_i);
        #1;
        rd = host_rdata_i;
        ab = {host_abort_i, host_ack_i};
        // Released bus shows the inverse, never a stale copy
        host_acc_o = '{req: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
        // One idle edge, so the strobe never toggles twice in a step
        @(posedge clk_i);
        #1;
    endtask
    task automatic attention(input logic [3:0] code, input logic [3:0] dev, output logic [1:0] ab);
        logic [31:0] rd;
        access(1'b1, 8'h04, {24'h00_0000, code, dev}, rd, ab);
    endtask
    // Full 50 us hold before command reset is dropped
    task automatic release_reset(output logic [1:0] ab);
        logic [31:0] rd;
        repeat (2500) @(posedge clk_i);
        #1;
        access(1'b1, 8'h05, 32'h0000_0000, rd, ab);
    endtask
endmodule

// *** shcp_ports_tb.sv ***
`timescale 1ns/1ps
module shcp_ports_tb;
    logic                      clk_i = 1'b0;
    logic                      arst_n_i = 1'b0;
    shcp_pkg::shcp_access_type host_acc;
    shcp_pkg::shcp_access_type local_acc = '0;
    shcp_pkg::shcp_action_type attention_port_action;
    logic [31:0]               host_rdata, local_rdata, rd;
    logic                      host_ack, host_abort, local_ack, attention_port_irq, cmd_reset, dma_enable, host_irq;
    logic [1:0]                dma_term = 2'b00, dma_dir_en = 2'b00, ab;
    logic                      wdog_pin = 1'b0;
    logic [15:0]               source_bits;
    int                        error_cnt = 0;
    int                        cmp_count = 0;
    always #10 clk_i = ~clk_i;
    shcp_ports u_shcp_ports (.clk_i(clk_i), .arst_n_i(arst_n_i), .host_acc_i(host_acc),
        .host_rdata_o(host_rdata), .host_ack_o(host_ack), .host_abort_o(host_abort),
        .local_acc_i(local_acc), .local_rdata_o(local_rdata), .local_ack_o(local_ack),
        .dma_term_i(dma_term), .dma_dir_en_i(dma_dir_en), .watchdog_i(wdog_pin), .attention_port_irq_o(attention_port_irq),
        .cmd_reset_o(cmd_reset), .dma_enable_o(dma_enable), .host_irq_o(host_irq),
        .attention_port_action_o(attention_port_action), .source_ident_bits_o(source_bits));
    shcp_host_model u_shcp_host_model (.clk_i(clk_i), .host_ack_i(host_ack), .host_abort_i(host_abort),
        .host_rdata_i(host_rdata), .host_acc_o(host_acc));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic hw(input logic [7:0] a, input logic [31:0] d);
        u_shcp_host_model.access(1'b1, a, d, rd, ab);
        chk({30'h0, ab}, 32'h1);
    endtask
    task automatic hr(input logic [7:0] a, input logic [31:0] e);
        u_shcp_host_model.access(1'b0, a, 32'h0, rd, ab);
        chk(rd, e);
    endtask
    task automatic lacc(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        local_acc = '{req: 1'b1, write: wr, addr: a, wdata: d};
        @(posedge clk_i);
        #1;
        if (!wr) chk(local_rdata, e);
        chk({31'h0, local_ack}, 32'h1);
        local_acc = '{req: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
        @(posedge clk_i);
        #1;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    function automatic shcp_pkg::shcp_action_type exp_act(input logic [3:0] c);
        case (c)
            4'h0: return shcp_pkg::SHCP_ACT_RESET;
            4'h1: return shcp_pkg::SHCP_ACT_IMMED;
            4'h3: return shcp_pkg::SHCP_ACT_BLOCK;
            4'h4, 4'hF: return shcp_pkg::SHCP_ACT_DEVDEP;
            4'hE: return shcp_pkg::SHCP_ACT_EOI;
            default: return shcp_pkg::SHCP_ACT_RSVD;
        endcase
    endfunction
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ****
    // Sequence
    // ****
    initial begin
        idle(10);
        arst_n_i = 1'b1;
        hr(8'h05, 32'h0000_0040);
        lacc(1'b0, 8'h07, 32'h0, 32'h0);
        hw(8'h05, 32'h0000_001F);
        chk(dma_enable, 32'h1);
        hr(8'h05, 32'h0000_005F);
        lacc(1'b1, 8'h05, 32'h0, 32'h0);
        lacc(1'b0, 8'h05, 32'h0, 32'h0000_005F);
        hw(8'h05, 32'h0000_0003);
        hw(8'h00, 32'h1234_5678);
        u_shcp_host_model.attention(4'h3, 4'h2, ab);
        chk(attention_port_irq, 32'h1);
        hr(8'h07, 32'h0000_0001);
        hw(8'h00, 32'hDEAD_BEEF);
        u_shcp_host_model.attention(4'h1, 4'h5, ab);
        lacc(1'b0, 8'h04, 32'h0, 32'h0000_0032);
        lacc(1'b0, 8'h00, 32'h0, 32'h1234_5678);
        u_shcp_host_model.attention(4'hD, 4'hA, ab);
        chk({attention_port_irq, source_bits}, 32'h0000_0400);
        hw(8'h05, 32'h0000_0023);
        hr(8'h07, 32'h0000_0000);
        hr(8'h05, 32'h0000_0043);
        for (int c = 0; c < 16; c++) begin
            if (c != 13) begin
                u_shcp_host_model.attention(c[3:0], 4'h0, ab);
                chk({29'h0, attention_port_action}, {29'h0, exp_act(c[3:0])});
                hw(8'h05, 32'h0000_0023);
            end
        end
        lacc(1'b0, 8'h04, 32'h0, 32'h0000_00F0);
        wdog_pin = 1'b1;
        idle(8);
        chk(host_irq, 32'h1);
        hw(8'h00, 32'h0BAD_0BAD);
        u_shcp_host_model.attention(4'h1, 4'h1, ab);
        chk(attention_port_irq, 32'h0);
        u_shcp_host_model.attention(4'hD, 4'h3, ab);
        chk({16'h0, source_bits}, 32'h0000_0408);
        hr(8'h07, 32'h0000_0033);
        chk(host_irq, 32'h0);
        lacc(1'b0, 8'h00, 32'h0, 32'h1234_5678);
        wdog_pin = 1'b0;
        hw(8'h05, 32'h0000_0023);
        dma_dir_en = 2'b01;
        dma_term = 2'b11;
        idle(6);
        chk(host_irq, 32'h1);
        hr(8'h07, 32'h0000_0024);
        hw(8'h05, 32'h0000_0002);
        dma_term = 2'b00;
        dma_dir_en = 2'b11;
        idle(6);
        dma_term = 2'b10;
        idle(6);
        chk(host_irq, 32'h0);
        hr(8'h07, 32'h0000_0028);
        lacc(1'b1, 8'h06, 32'h0000_005A, 32'h0);
        hw(8'h06, 32'h0000_00FF);
        hr(8'h06, 32'h0000_005A);
        hw(8'h05, 32'h0000_0080);
        chk(cmd_reset, 32'h1);
        u_shcp_host_model.access(1'b0, 8'h06, 32'h0, rd, ab);
        chk({30'h0, ab}, 32'h2);
        lacc(1'b0, 8'h07, 32'h0, 32'h0000_0021);
        hr(8'h05, 32'h0000_00C0);
        u_shcp_host_model.release_reset(ab);
        hr(8'h06, 32'h0000_005A);
        hw(8'h05, 32'h0000_0020);
        hr(8'h07, 32'h0000_0020);
        final_report;
    end
    // Run needs about 2700 cycles; limit at 20000
    initial begin
        #(20 * 20000);
        error_cnt++;
        final_report;
    end
endmodule
